// file: pspcr_chk.sv
// Concurrent checks on the ports of the command register top.
// Assumes one clock domain; attached by the bind at the foot of this file.
`timescale 1ns/10ps
module pspcr_chk (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// Watched ports
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_write_i,
	input  wire logic        cmd_word_i,
	input  wire logic [7:0]  cmd_code_i,
	input  wire logic        enable_i,
	input  wire logic        rsp_valid_o,
	input  wire logic        rsp_ack_o,
	input  wire logic [15:0] rsp_data_o,
	input  wire logic        out_rising_o,
	input  wire logic        out_active_o,
	input  wire logic        out_falling_o,
	input  wire logic        fault_off_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	wire ro_code = (cmd_code_i == 8'h20) || (cmd_code_i >= 8'h78 && cmd_code_i <= 8'h7C);
	wire rsp_code = cmd_code_i inside {8'h41, 8'h45, 8'h50, 8'h54, 8'h56, 8'h5A};

	AST_RSP_NEXT: assert property (cmd_valid_i |=> rsp_valid_o)
		else $error("no response one cycle after a command");
	AST_RSP_QUIET: assert property (!cmd_valid_i |=> !rsp_valid_o)
		else $error("response without a command");
	AST_RO_WRITE: assert property (cmd_valid_i && cmd_write_i && ro_code |=> !rsp_ack_o)
		else $error("write to a read-only command accepted");
	AST_MODE: assert property (cmd_valid_i && !cmd_write_i && cmd_code_i == 8'h20
		&& !cmd_word_i |=> rsp_data_o == (rsp_ack_o ? 16'h0013 : 16'h0000))
		else $error("mode byte read wrong");
	AST_BYTE_SIZE: assert property (cmd_valid_i && cmd_word_i && rsp_code |=> !rsp_ack_o)
		else $error("word transfer to a response byte accepted");
	AST_FAULT_OFF: assert property (fault_off_o |-> !out_active_o && !out_rising_o
		&& !out_falling_o)
		else $error("output running during fault shutdown");
	AST_RAMP_ACTIVE: assert property (out_rising_o || out_falling_o |-> out_active_o)
		else $error("ramp without active output");
	AST_RISE_EN: assert property ($rose(out_rising_o) |-> $past(enable_i))
		else $error("ramp up without enable");
	AST_FALL_ACT: assert property ($rose(out_falling_o) |-> $past(out_active_o)
		&& !out_rising_o)
		else $error("ramp down not preceded by active output");
endmodule

bind pspcr_top pspcr_chk u_pspcr_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
	.cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_word_i(cmd_word_i),
	.cmd_code_i(cmd_code_i), .enable_i(enable_i), .rsp_valid_o(rsp_valid_o),
	.rsp_ack_o(rsp_ack_o), .rsp_data_o(rsp_data_o), .out_rising_o(out_rising_o),
	.out_active_o(out_active_o), .out_falling_o(out_falling_o), .fault_off_o(fault_off_o));

// file: pspcr_host.sv
// Host controller model issuing one command at a time on the command port.
// Assumes the answer stands for the one cycle after the request is taken.
`timescale 1ns/10ps
module pspcr_host (
	// Clock
	input  wire logic        ref_clk_i,
	// Command port
	output logic             cmd_valid_o,
	output logic             cmd_write_o,
	output logic             cmd_word_o,
	output logic [7:0]       cmd_code_o,
	output logic [15:0]      cmd_wdata_o,
	input  wire logic        rsp_valid_i,
	input  wire logic        rsp_ack_i,
	input  wire logic [15:0] rsp_data_i
);
	initial
	begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_word_o  = 1'b0;
		cmd_code_o  = 8'h00;
		cmd_wdata_o = 16'h0000;
	end

	// Released code and data lines carry the inverse of the last value so stale data never looks fresh.
	task automatic xfer(input logic wr, input logic wd, input logic [7:0] code,
		input logic [15:0] wdata, output logic ok, output logic [15:0] rdata);
		@(posedge ref_clk_i);
		cmd_valid_o <= 1'b1;
		cmd_write_o <= wr;
		cmd_word_o  <= wd;
		cmd_code_o  <= code;
		cmd_wdata_o <= wdata;
		@(posedge ref_clk_i);
		cmd_valid_o <= 1'b0;
		cmd_code_o  <= ~code;
		cmd_wdata_o <= ~wdata;
		@(posedge ref_clk_i);
		ok    = (rsp_valid_i === 1'b1) && (rsp_ack_i === 1'b1);
		rdata = rsp_data_i;
	endtask
endmodule

// file: pspcr_if.sv
// Carriers between the command register top and its sequencer and status helpers.
// Assumes all parties run on one clock.
`timescale 1ns/10ps
interface pspcr_seq_if;
	logic        enable;
	logic        kill;
	logic [15:0] on_dly;
	logic [15:0] on_rise;
	logic [15:0] off_dly;
	logic [15:0] off_fall;
	logic        rising;
	logic        active;
	logic        falling;
	modport ctl (output enable, kill, on_dly, on_rise, off_dly, off_fall,
		input rising, active, falling);
	modport seq (input enable, kill, on_dly, on_rise, off_dly, off_fall,
		output rising, active, falling);
endinterface

interface pspcr_stat_if;
	logic [7:0] evt;
	logic       clear;
	logic [7:0] flags;
	modport ctl (output evt, clear, input flags);
	modport stat (input evt, clear, output flags);
endinterface

// file: pspcr_pkg.sv
// Constants, types and helpers shared by the power stage command register set.
// Assumes a command-level port: serial framing of the management bus is done outside.
package pspcr_pkg;

	localparam int              PSPCR_NREG = 30;
	localparam logic [7:0]      PSPCR_CODE_TAB [PSPCR_NREG] = '{
		8'h33, 8'h37, 8'h38, 8'h39, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
		8'h46, 8'h4A, 8'h4B, 8'h4F, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55,
		8'h56, 8'h57, 8'h58, 8'h59, 8'h5A, 8'h5E, 8'h60, 8'h61, 8'h64, 8'h65};
	// Slots that carry a byte command rather than a word command.
	localparam logic [29:0]     PSPCR_BYTE_MASK = 30'h01144220;
	localparam logic [15:0]     PSPCR_RST_TAB [PSPCR_NREG] = '{
		16'h0000, 16'h0000, 16'hB370, 16'h0000, 16'h0000, 16'h0080, 16'h0000,
		16'h0000, 16'h0000, 16'h0080, 16'hEAD0, 16'hEA88, 16'hE4E0, 16'hEBE8,
		16'h0080, 16'hEB48, 16'hDC40, 16'hE580, 16'h0080, 16'hD380, 16'h0080,
		16'hD353, 16'h0000, 16'h0000, 16'h0080, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000};

	localparam int              S_FREQ     = 0;
	localparam int              S_VOV_FL   = 4;
	localparam int              S_VOV_RSP  = 5;
	localparam int              S_VOV_WL   = 6;
	localparam int              S_VUV_WL   = 7;
	localparam int              S_VUV_FL   = 8;
	localparam int              S_VUV_RSP  = 9;
	localparam int              S_OCW      = 11;
	localparam int              S_OT_RSP   = 14;
	localparam int              S_UT_RSP   = 18;
	localparam int              S_VINO_RSP = 20;
	localparam int              S_VINU_WL  = 22;
	localparam int              S_VINU_FL  = 23;
	localparam int              S_VINU_RSP = 24;
	localparam int              S_PG       = 25;
	localparam int              S_TON_DLY  = 26;
	localparam int              S_TURN_ON_RAMP_TIME = 27;
	localparam int              S_TOF_DLY  = 28;
	localparam int              S_TOF_FALL = 29;

	localparam logic [7:0]      PSPCR_CODE_MODE  = 8'h20;
	localparam logic [7:0]      PSPCR_MODE_VAL   = 8'h13;
	localparam logic [7:0]      PSPCR_CODE_SBYTE = 8'h78;
	localparam logic [7:0]      PSPCR_CODE_SWORD = 8'h79;
	localparam logic [7:0]      PSPCR_CODE_SVOUT = 8'h7A;
	localparam logic [7:0]      PSPCR_CODE_SIOUT = 8'h7B;
	localparam logic [7:0]      PSPCR_CODE_SIN   = 8'h7C;

	localparam logic [31:0]     PCT_VOV_F = 32'h00000073;
	localparam logic [31:0]     PCT_VOV_W = 32'h0000006E;
	localparam logic [31:0]     PCT_VUV_W = 32'h0000005A;
	localparam logic [31:0]     PCT_VUV_F = 32'h00000055;
	localparam logic [31:0]     PCT_PG    = 32'h0000005A;
	localparam logic [31:0]     PCT_VINUW = 32'h00000069;
	localparam logic [31:0]     PCT_DEN   = 32'h00000064;

	// Event and flag positions.
	localparam int              E_VOV = 0;
	localparam int              E_VUV = 1;
	localparam int              E_IOC = 2;
	localparam int              E_IUC = 3;
	localparam int              E_VINO = 4;
	localparam int              E_VINU = 5;
	localparam int              E_OT = 6;
	localparam int              E_UT = 7;
	localparam int              B_SB_VOV = 5;
	localparam int              B_SB_IOC = 4;
	localparam int              B_SB_VINU = 3;
	localparam int              B_SB_TEMP = 2;
	localparam int              B_SB_OTHER = 0;
	localparam int              B_SW_VOUT = 15;
	localparam int              B_SW_IOUT = 14;
	localparam int              B_SW_IN = 13;
	localparam int              B_FLT_HI = 7;
	localparam int              B_FLT_LO = 4;
	localparam logic [1:0]      PSPCR_RSP_OFF = 2'h2;

	localparam int              PSPCR_CLK_MHZ = 250;
	localparam int              PSPCR_TICK_US = 1000;
	localparam int              PSPCR_TICK_CYC = PSPCR_TICK_US * PSPCR_CLK_MHZ;

	typedef enum logic [2:0] {
		SEQ_OFF  = 3'b000,
		SEQ_DON  = 3'b001,
		SEQ_RISE = 3'b010,
		SEQ_ON   = 3'b011,
		SEQ_DOFF = 3'b100,
		SEQ_FALL = 3'b101
	} pspcr_seq_e;

	typedef struct packed {
		logic       hit;
		logic       is_byte;
		logic [4:0] slot;
	} pspcr_cmd_s;

	// Whole milliseconds of a linear word; negative values give zero, large ones saturate.
	function automatic logic [15:0] pspcr_l11_ms(input logic [15:0] w);
		int          e;
		logic [31:0] m;
		e = int'(signed'(w[15:11]));
		m = {21'h000000, w[10:0]};
		if (w[10])
			return 16'h0000;
		m = (e < 0) ? (m >> (-e)) : (m << e);
		return (|m[31:16]) ? 16'hFFFF : m[15:0];
	endfunction

	function automatic logic [15:0] pspcr_l16_scale(input logic [15:0] v, input logic [31:0] p);
		logic [31:0] t;
		t = ({16'h0000, v} * p) / PCT_DEN;
		return (|t[31:16]) ? 16'hFFFF : t[15:0];
	endfunction

	// The exponent is bumped when the scaled mantissa would leave its positive range.
	function automatic logic [15:0] pspcr_l11_scale(input logic [15:0] w, input logic [31:0] p);
		logic [31:0] t;
		logic [4:0]  e;
		t = ({21'h000000, w[10:0]} * p) / PCT_DEN;
		e = w[15:11];
		if (|t[31:10])
		begin
			t = t >> 1;
			e = e + 5'h01;
		end
		return {e, t[10:0]};
	endfunction

endpackage

// file: pspcr_seq.sv
// Turn-on and turn-off sequencer counting whole milliseconds.
// Assumes delays and ramp times arrive already converted to millisecond counts.
`timescale 1ns/10ps
module pspcr_seq #(
	parameter int TICK_CYC = pspcr_pkg::PSPCR_TICK_CYC
) (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_b_i,
	// Control
	pspcr_seq_if.seq  sq
);
	import pspcr_pkg::*;

	logic [31:0] tick_cnt_q;
	logic        tick;
	logic [15:0] ms_q;
	pspcr_seq_e  state_q;
	pspcr_seq_e  state_d;

	assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			tick_cnt_q <= 32'h00000000;
		else
			tick_cnt_q <= tick ? 32'h00000000 : tick_cnt_q + 32'h00000001;
	end

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			SEQ_OFF:  if (sq.enable) state_d = SEQ_DON;
			SEQ_DON:  if (!sq.enable) state_d = SEQ_OFF;
			          else if (ms_q >= sq.on_dly) state_d = SEQ_RISE;
			SEQ_RISE: if (!sq.enable) state_d = SEQ_DOFF;
			          else if (ms_q >= sq.on_rise) state_d = SEQ_ON;
			SEQ_ON:   if (!sq.enable) state_d = SEQ_DOFF;
			SEQ_DOFF: if (ms_q >= sq.off_dly) state_d = SEQ_FALL;
			SEQ_FALL: if (ms_q >= sq.off_fall) state_d = SEQ_OFF;
			default:  state_d = SEQ_OFF;
		endcase
		// A shutdown fault drops the output at once, skipping the soft stop.
		if (sq.kill)
			state_d = SEQ_OFF;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_q    <= SEQ_OFF;
			ms_q       <= 16'h0000;
			sq.rising  <= 1'b0;
			sq.active  <= 1'b0;
			sq.falling <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			if (state_d != state_q)
				ms_q <= 16'h0000;
			else if (tick && ms_q != 16'hFFFF)
				ms_q <= ms_q + 16'h0001;
			sq.rising  <= (state_d == SEQ_RISE);
			sq.active  <= (state_d != SEQ_OFF) && (state_d != SEQ_DON);
			sq.falling <= (state_d == SEQ_FALL);
		end
	end
endmodule

// file: pspcr_stat.sv
// Sticky fault flags behind the status commands.
// Assumes event inputs are one-cycle or level indications from the monitors.
`timescale 1ns/10ps
module pspcr_stat (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_b_i,
	// Events and flags
	pspcr_stat_if.stat st
);
	import pspcr_pkg::*;

	// A new event in the clearing cycle survives the clear.
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			st.flags <= 8'h00;
		else
			st.flags <= (st.flags & ~{8{st.clear}}) | st.evt;
	end
endmodule

// file: pspcr_top.sv
// Command register set of the step-down power stage: limits, responses, timing, status.
// Assumes a command-level port fed by an outside bus framer, and strap values
// that are stable while reset is released.
`timescale 1ns/10ps
module pspcr_top #(
	parameter int       TICK_CYC   = pspcr_pkg::PSPCR_TICK_CYC,
	parameter bit       HAS_OC_WARN = 1'b1
) (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// Command port
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_write_i,
	input  wire logic        cmd_word_i,
	input  wire logic [7:0]  cmd_code_i,
	input  wire logic [15:0] cmd_wdata_i,
	output logic             rsp_valid_o,
	output logic             rsp_ack_o,
	output logic [15:0]      rsp_data_o,
	// Strap values
	input  wire logic [15:0] strap_freq_i,
	input  wire logic [15:0] strap_vout_i,
	input  wire logic [15:0] strap_vin_uv_i,
	input  wire logic [15:0] strap_ton_dly_i,
	input  wire logic [15:0] strap_turn_on_ramp_time_i,
	input  wire logic [15:0] strap_toff_dly_i,
	input  wire logic [15:0] strap_turn_off_ramp_time_i,
	// Power control and monitors
	input  wire logic        enable_i,
	input  wire logic [7:0]  fault_evt_i,
	input  wire logic        clear_faults_i,
	output logic             out_rising_o,
	output logic             out_active_o,
	output logic             out_falling_o,
	output logic             fault_off_o
);
	import pspcr_pkg::*;

	pspcr_seq_if  sq ();
	pspcr_stat_if st ();

	logic [15:0] regs_q [PSPCR_NREG];
	logic        loaded_q;
	pspcr_cmd_s  info;
	logic        rd_ok;
	logic        wr_ok;
	logic [15:0] rd_val;
	logic [7:0]  sbyte;
	logic [15:0] sword;
	logic [7:0]  f;
	logic        kill;

	function automatic pspcr_cmd_s lookup(input logic [7:0] code);
		pspcr_cmd_s r;
		r = '0;
		for (int i = 0; i < PSPCR_NREG; i++)
			if (code == PSPCR_CODE_TAB[i])
			begin
				r.hit     = 1'b1;
				r.is_byte = PSPCR_BYTE_MASK[i];
				r.slot    = 5'(i);
			end
		if (!HAS_OC_WARN && r.slot == 5'(S_OCW))
			r.hit = 1'b0;
		return r;
	endfunction

	function automatic logic shut(input logic [15:0] rsp);
		return rsp[7:6] == PSPCR_RSP_OFF;
	endfunction

	assign info = lookup(cmd_code_i);
	assign f    = st.flags;

	// Status composition; every bit comes from a sticky flag, so no fault means zero.
	always_comb
	begin
		sbyte             = 8'h00;
		sbyte[B_SB_VOV]   = f[E_VOV];
		sbyte[B_SB_IOC]   = f[E_IOC];
		sbyte[B_SB_VINU]  = f[E_VINU];
		sbyte[B_SB_TEMP]  = f[E_OT] | f[E_UT];
		sbyte[B_SB_OTHER] = f[E_VUV] | f[E_IUC] | f[E_VINO];
		sword             = {8'h00, sbyte};
		sword[B_SW_VOUT]  = f[E_VOV] | f[E_VUV];
		sword[B_SW_IOUT]  = f[E_IOC] | f[E_IUC];
		sword[B_SW_IN]    = f[E_VINO] | f[E_VINU];
	end

	// Read decode; transfer size must match the command type.
	always_comb
	begin
		rd_ok  = 1'b0;
		rd_val = 16'h0000;
		if (info.hit)
		begin
			rd_ok  = (cmd_word_i == !info.is_byte);
			rd_val = regs_q[info.slot];
		end
		else
		begin
			case (cmd_code_i)
				PSPCR_CODE_MODE:
				begin
					rd_ok  = !cmd_word_i;
					rd_val = {8'h00, PSPCR_MODE_VAL};
				end
				PSPCR_CODE_SBYTE:
				begin
					rd_ok  = !cmd_word_i;
					rd_val = {8'h00, sbyte};
				end
				PSPCR_CODE_SWORD:
				begin
					rd_ok  = cmd_word_i;
					rd_val = sword;
				end
				PSPCR_CODE_SVOUT:
				begin
					rd_ok            = !cmd_word_i;
					rd_val[B_FLT_HI] = f[E_VOV];
					rd_val[B_FLT_LO] = f[E_VUV];
				end
				PSPCR_CODE_SIOUT:
				begin
					rd_ok            = !cmd_word_i;
					rd_val[B_FLT_HI] = f[E_IOC];
					rd_val[B_FLT_LO] = f[E_IUC];
				end
				PSPCR_CODE_SIN:
				begin
					rd_ok            = !cmd_word_i;
					rd_val[B_FLT_HI] = f[E_VINO];
					rd_val[B_FLT_LO] = f[E_VINU];
				end
				default:
				begin
					rd_ok  = 1'b0;
					rd_val = 16'h0000;
				end
			endcase
		end
	end

	// Read-only codes never match the writable table, so writes to them are refused.
	assign wr_ok = cmd_valid_i && cmd_write_i && loaded_q && info.hit
		&& (cmd_word_i == !info.is_byte);

	// Straps are caught on the first edge after reset release, never under reset.
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			loaded_q <= 1'b0;
		else
			loaded_q <= 1'b1;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < PSPCR_NREG; i++)
				regs_q[i] <= PSPCR_RST_TAB[i];
		end
		else if (!loaded_q)
		begin
			regs_q[S_FREQ]     <= strap_freq_i;
			regs_q[S_VOV_FL]   <= pspcr_l16_scale(strap_vout_i, PCT_VOV_F);
			regs_q[S_VOV_WL]   <= pspcr_l16_scale(strap_vout_i, PCT_VOV_W);
			regs_q[S_VUV_WL]   <= pspcr_l16_scale(strap_vout_i, PCT_VUV_W);
			regs_q[S_VUV_FL]   <= pspcr_l16_scale(strap_vout_i, PCT_VUV_F);
			regs_q[S_PG]       <= pspcr_l16_scale(strap_vout_i, PCT_PG);
			regs_q[S_VINU_FL]  <= strap_vin_uv_i;
			regs_q[S_VINU_WL]  <= pspcr_l11_scale(strap_vin_uv_i, PCT_VINUW);
			regs_q[S_TON_DLY]  <= strap_ton_dly_i;
			regs_q[S_TURN_ON_RAMP_TIME] <= strap_turn_on_ramp_time_i;
			regs_q[S_TOF_DLY]  <= strap_toff_dly_i;
			regs_q[S_TOF_FALL] <= strap_turn_off_ramp_time_i;
		end
		else if (wr_ok)
			regs_q[info.slot] <= info.is_byte ? {8'h00, cmd_wdata_i[7:0]} : cmd_wdata_i;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rsp_valid_o <= 1'b0;
			rsp_ack_o   <= 1'b0;
			rsp_data_o  <= 16'h0000;
		end
		else
		begin
			rsp_valid_o <= cmd_valid_i;
			rsp_ack_o   <= cmd_valid_i && (cmd_write_i ? wr_ok : (rd_ok && loaded_q));
			rsp_data_o  <= (cmd_valid_i && !cmd_write_i && rd_ok && loaded_q) ? rd_val : 16'h0000;
		end
	end

	// Any fault whose response says disable turns the output off until enable drops.
	assign kill = (fault_evt_i[E_VOV] && shut(regs_q[S_VOV_RSP]))
		|| (fault_evt_i[E_VUV] && shut(regs_q[S_VUV_RSP]))
		|| (fault_evt_i[E_OT] && shut(regs_q[S_OT_RSP]))
		|| (fault_evt_i[E_UT] && shut(regs_q[S_UT_RSP]))
		|| (fault_evt_i[E_VINO] && shut(regs_q[S_VINO_RSP]))
		|| (fault_evt_i[E_VINU] && shut(regs_q[S_VINU_RSP]));

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			fault_off_o <= 1'b0;
		else if (kill)
			fault_off_o <= 1'b1;
		else if (!enable_i)
			fault_off_o <= 1'b0;
	end

	// Timing words are linear; the sequencer counts their whole-millisecond value.
	assign sq.enable   = enable_i && !fault_off_o && loaded_q;
	assign sq.kill     = kill;
	assign sq.on_dly   = pspcr_l11_ms(regs_q[S_TON_DLY]);
	assign sq.on_rise  = pspcr_l11_ms(regs_q[S_TURN_ON_RAMP_TIME]);
	assign sq.off_dly  = pspcr_l11_ms(regs_q[S_TOF_DLY]);
	assign sq.off_fall = pspcr_l11_ms(regs_q[S_TOF_FALL]);
	assign st.evt      = fault_evt_i;
	assign st.clear    = clear_faults_i;

	// Outputs come straight from the sequencer's flip-flops.
	assign out_rising_o  = sq.rising;
	assign out_active_o  = sq.active;
	assign out_falling_o = sq.falling;

	pspcr_seq #(
		.TICK_CYC (TICK_CYC)
	) u_seq (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.sq        (sq.seq)
	);

	pspcr_stat u_stat (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.st        (st.stat)
	);
endmodule

// file: test_power_stage_command_register_set.sv
// Self-checking bench for the command register top against a register model.
// Assumes the host model in its own file and a shortened millisecond tick.
`timescale 1ns/10ps
module test_power_stage_command_register_set;
	import pspcr_pkg::*;
	localparam int TK = 4;
	logic        ref_clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        cmd_valid_i, cmd_write_i, cmd_word_i, rsp_valid_o, rsp_ack_o;
	logic [7:0]  cmd_code_i, fault_evt_i;
	logic [15:0] cmd_wdata_i, rsp_data_o, strap_freq_i, strap_vout_i, strap_vin_uv_i;
	logic [15:0] strap_ton_dly_i, strap_turn_on_ramp_time_i, strap_toff_dly_i, strap_turn_off_ramp_time_i;
	logic        enable_i, clear_faults_i, out_rising_o, out_active_o;
	logic        out_falling_o, fault_off_o;
	logic        nw_valid, nw_ack;
	logic [15:0] mdl [PSPCR_NREG];
	logic [15:0] tim [4] = '{16'h0002, 16'h0003, 16'h0001, 16'h0002};
	logic [15:0] w;
	int          seed = 7054;
	int          errors = 0;
	int          total_checks = 0;
	int          n;

	always #2 ref_clk_i = ~ref_clk_i;

	pspcr_host u_pspcr_host (.ref_clk_i(ref_clk_i), .cmd_valid_o(cmd_valid_i),
		.cmd_write_o(cmd_write_i), .cmd_word_o(cmd_word_i), .cmd_code_o(cmd_code_i),
		.cmd_wdata_o(cmd_wdata_i), .rsp_valid_i(rsp_valid_o), .rsp_ack_i(rsp_ack_o),
		.rsp_data_i(rsp_data_o));

	pspcr_top #(.TICK_CYC(TK), .HAS_OC_WARN(1'b1)) u_pspcr_top (.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
		.cmd_word_i(cmd_word_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
		.rsp_valid_o(rsp_valid_o), .rsp_ack_o(rsp_ack_o), .rsp_data_o(rsp_data_o),
		.strap_freq_i(strap_freq_i), .strap_vout_i(strap_vout_i),
		.strap_vin_uv_i(strap_vin_uv_i), .strap_ton_dly_i(strap_ton_dly_i),
		.strap_turn_on_ramp_time_i(strap_turn_on_ramp_time_i), .strap_toff_dly_i(strap_toff_dly_i),
		.strap_turn_off_ramp_time_i(strap_turn_off_ramp_time_i), .enable_i(enable_i),
		.fault_evt_i(fault_evt_i), .clear_faults_i(clear_faults_i),
		.out_rising_o(out_rising_o), .out_active_o(out_active_o),
		.out_falling_o(out_falling_o), .fault_off_o(fault_off_o));

	// A second copy built without the optional warning limit must refuse that command.
	pspcr_top #(.TICK_CYC(TK), .HAS_OC_WARN(1'b0)) u_pspcr_top_nw (.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
		.cmd_word_i(cmd_word_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
		.rsp_valid_o(nw_valid), .rsp_ack_o(nw_ack), .rsp_data_o(),
		.strap_freq_i(strap_freq_i), .strap_vout_i(strap_vout_i),
		.strap_vin_uv_i(strap_vin_uv_i), .strap_ton_dly_i(strap_ton_dly_i),
		.strap_turn_on_ramp_time_i(strap_turn_on_ramp_time_i), .strap_toff_dly_i(strap_toff_dly_i),
		.strap_turn_off_ramp_time_i(strap_turn_off_ramp_time_i), .enable_i(enable_i),
		.fault_evt_i(fault_evt_i), .clear_faults_i(clear_faults_i), .out_rising_o(),
		.out_active_o(), .out_falling_o(), .fault_off_o());

	function automatic logic [15:0] pct(input logic [15:0] v, input int p);
		int t;
		t = int'(v) * p / 100;
		return (t > 65535) ? 16'hFFFF : t[15:0];
	endfunction

	// The exponent steps up when the scaled mantissa would leave its positive range.
	function automatic logic [15:0] uvw(input logic [15:0] v);
		int         t;
		logic [4:0] e;
		t = int'(v[10:0]) * 105 / 100;
		e = v[15:11];
		if (t > 1023)
		begin
			t = t / 2;
			e = e + 5'h01;
		end
		return {e, t[10:0]};
	endfunction

	task automatic close_out;
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic wr, input logic wd, input logic [7:0] c,
		input logic [15:0] wdv, input logic ea, input logic [15:0] ed);
		logic        ok;
		logic [15:0] rd;
		u_pspcr_host.xfer(wr, wd, c, wdv, ok, rd);
		chk({15'h0000, ok}, {15'h0000, ea});
		chk(rd, ed);
	endtask

	// Levels: 0 rising high, 1 rising low, 2 falling high, 3 active low.
	task automatic wt(input int sel, input int lo, input int hi);
		int c;
		c = 0;
		do
		begin
			@(posedge ref_clk_i);
			c++;
		end
		while (c < 1000 && !(sel == 0 ? out_rising_o === 1'b1 : sel == 1 ? out_rising_o === 1'b0
			: sel == 2 ? out_falling_o === 1'b1 : out_active_o === 1'b0));
		chk({15'h0000, c >= lo && c <= hi}, 16'h0001);
	endtask

	task automatic evt(input logic [7:0] e, input logic clr);
		@(posedge ref_clk_i);
		fault_evt_i    <= e;
		clear_faults_i <= clr;
		@(posedge ref_clk_i);
		fault_evt_i    <= 8'h00;
		clear_faults_i <= 1'b0;
	endtask

	initial
	begin
		#(40000 * 4);
		errors++;
		close_out();
	end

	initial
	begin
		strap_freq_i = 16'($random(seed));
		strap_vout_i = 16'($random(seed));
		strap_vin_uv_i = 16'($random(seed));
		strap_ton_dly_i = tim[0];
		strap_turn_on_ramp_time_i = tim[1];
		strap_toff_dly_i = tim[2];
		strap_turn_off_ramp_time_i = tim[3];
		enable_i = 1'b0;
		fault_evt_i = 8'h00;
		clear_faults_i = 1'b0;
		mdl = PSPCR_RST_TAB;
		mdl[S_FREQ] = strap_freq_i;
		mdl[S_VOV_FL] = pct(strap_vout_i, 115);
		mdl[S_VOV_WL] = pct(strap_vout_i, 110);
		mdl[S_VUV_WL] = pct(strap_vout_i, 90);
		mdl[S_VUV_FL] = pct(strap_vout_i, 85);
		mdl[S_PG] = pct(strap_vout_i, 90);
		mdl[S_VINU_FL] = strap_vin_uv_i;
		mdl[S_VINU_WL] = uvw(strap_vin_uv_i);
		for (int i = 0; i < 4; i++)
			mdl[S_TON_DLY + i] = tim[i];
		repeat (16) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		for (int i = 0; i < PSPCR_NREG; i++)
		begin
			acc(1'b0, !PSPCR_BYTE_MASK[i], PSPCR_CODE_TAB[i], 16'h0000, 1'b1, mdl[i]);
			if (i == S_OCW)
				chk({14'h0000, nw_valid, nw_ack}, 16'h0002);
		end
		acc(1'b0, 1'b0, 8'h20, 16'h0000, 1'b1, 16'h0013);
		acc(1'b1, 1'b0, 8'h20, 16'h0055, 1'b0, 16'h0000);
		for (int c = 8'h78; c <= 8'h7C; c++)
		begin
			acc(1'b1, c == 8'h79, c[7:0], 16'hFFFF, 1'b0, 16'h0000);
			acc(1'b0, c == 8'h79, c[7:0], 16'h0000, 1'b1, 16'h0000);
		end
		acc(1'b1, 1'b1, 8'h41, 16'h0000, 1'b0, 16'h0000);
		acc(1'b0, 1'b0, 8'h41, 16'h0000, 1'b1, 16'h0080);
		acc(1'b0, 1'b1, 8'h30, 16'h0000, 1'b0, 16'h0000);
		for (int i = 0; i < PSPCR_NREG; i++)
		begin
			w = 16'($random(seed));
			mdl[i] = PSPCR_BYTE_MASK[i] ? {8'h00, w[7:0]} : w;
			acc(1'b1, !PSPCR_BYTE_MASK[i], PSPCR_CODE_TAB[i], w, 1'b1, 16'h0000);
			acc(1'b0, !PSPCR_BYTE_MASK[i], PSPCR_CODE_TAB[i], 16'h0000, 1'b1, mdl[i]);
		end
		for (int i = 0; i < 4; i++)
			acc(1'b1, 1'b1, PSPCR_CODE_TAB[S_TON_DLY + i], tim[i], 1'b1, 16'h0000);
		acc(1'b1, 1'b0, 8'h50, 16'h0080, 1'b1, 16'h0000);
		acc(1'b1, 1'b0, 8'h45, 16'h0080, 1'b1, 16'h0000);
		@(posedge ref_clk_i);
		enable_i <= 1'b1;
		wt(0, 2 * TK, 3 * TK + 3);
		wt(1, 3 * TK, 4 * TK + 3);
		enable_i <= 1'b0;
		wt(2, 1 * TK, 2 * TK + 3);
		wt(3, 2 * TK, 3 * TK + 3);
		enable_i <= 1'b1;
		wt(0, 2 * TK, 3 * TK + 3);
		evt(8'h40, 1'b0);
		@(posedge ref_clk_i);
		chk({14'h0000, fault_off_o, out_active_o}, 16'h0002);
		acc(1'b0, 1'b0, 8'h78, 16'h0000, 1'b1, 16'h0004);
		evt(8'h04, 1'b0);
		acc(1'b0, 1'b1, 8'h79, 16'h0000, 1'b1, 16'h4014);
		acc(1'b0, 1'b0, 8'h7B, 16'h0000, 1'b1, 16'h0080);
		evt(8'h00, 1'b1);
		acc(1'b0, 1'b1, 8'h79, 16'h0000, 1'b1, 16'h0000);
		enable_i <= 1'b0;
		evt(8'h02, 1'b0);
		acc(1'b0, 1'b0, 8'h7A, 16'h0000, 1'b1, 16'h0010);
		acc(1'b0, 1'b0, 8'h78, 16'h0000, 1'b1, 16'h0001);
		chk({15'h0000, fault_off_o}, 16'h0000);
		// A reset in mid-run must restore table values and reload straps.
		rst_b_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		acc(1'b0, 1'b1, 8'h46, 16'h0000, 1'b1, 16'hEAD0);
		acc(1'b0, 1'b1, 8'h33, 16'h0000, 1'b1, strap_freq_i);
		acc(1'b0, 1'b0, 8'h78, 16'h0000, 1'b1, 16'h0000);
		close_out();
	end
endmodule
